// file: verilog/pao_pkg.sv
// Package: constants and carrier types for the pipelined converter output port
package pao_pkg;
    localparam int STAGES      = 9;      // 1.5-bit quantizer stages
    localparam int STAGE_W     = 2;      // Bits per stage digit
    localparam int WORD_W      = 10;     // Output word width
    localparam int LATENCY     = 5;      // Convert cycles from sample to valid word
    localparam int LAT_W       = 3;      // Width of the latency counter
    localparam logic [LAT_W-1:0] LAT_CNT = 3'h5;
    localparam logic [WORD_W-1:0] MIDSCALE = 10'h200;
    localparam logic [WORD_W-1:0] ZERO_WORD = 10'h000;

    typedef logic [STAGE_W-1:0] pao_digit_t;

    // One sample's raw stage decisions, stage 0 first
    typedef struct packed {
        pao_digit_t [STAGES-1:0] digit;
    } pao_raw_t;

    // Bus drive: data and per-line output enable
    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic [WORD_W-1:0] oe;
    } pao_bus_t;
endpackage : pao_pkg

// file: verilog/pao_align_line.sv
// Delay line that delays one stage's digit by DEPTH clocks
`timescale 1ns/1ps
`default_nettype none
module pao_align_line
    import pao_pkg::*;
#(
    parameter int DEPTH = 1
)
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire pao_digit_t i_digit,
    output pao_digit_t      o_digit
);
    pao_digit_t tap [DEPTH];

    // Shift chain; each digit comes out DEPTH clocks after it went in
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int k = 0; k < DEPTH; k++)
                tap[k] <= '0;
        end
        else
        begin
            tap[0] <= i_digit;
            for (int k = 1; k < DEPTH; k++)
                tap[k] <= tap[k-1];
        end
    end

    assign o_digit = tap[DEPTH-1];
endmodule // pao_align_line
`default_nettype wire

// file: verilog/pao_port.sv
// Top: stage alignment, error correction and tri-state output bus
// Stage digits come from the analog quantizers, sampled on i_clk. Each
// stage digit takes a value 0..2 (1.5 bits redundant coding); error
// correction adds them with one bit of overlap between neighbours.
// The last stage carries the same weight as the one before it, so that
// all digits at 1 land exactly on midscale and all at 0 on zero.
// All digits of one sample arrive together, so every delay line has the
// same depth; the output register adds the final cycle of latency.
`timescale 1ns/1ps
`default_nettype none
module pao_port
    import pao_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_rst_n,
    input  wire pao_raw_t i_raw,
    input  wire logic     i_oe_n,
    input  wire logic     i_pwrdn,
    output pao_bus_t      o_bus,
    output logic          o_word_valid
);
    // Pin synchronisers for the two static control pins
    logic oe_n_s1;
    logic oe_n_s2;
    logic pd_s1;
    logic pd_s2;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            oe_n_s1 <= 1'b0;
            oe_n_s2 <= 1'b0;
            pd_s1   <= 1'b0;
            pd_s2   <= 1'b0;
        end
        else
        begin
            oe_n_s1 <= i_oe_n;
            oe_n_s2 <= oe_n_s1;
            pd_s1   <= i_pwrdn;
            pd_s2   <= pd_s1;
        end
    end

    // Every stage is delayed LATENCY-1 cycles; the output register makes five
    pao_digit_t aligned [STAGES];

    genvar g;
    generate
        for (g = 0; g < STAGES; g++)
        begin : g_align
            pao_align_line #(
                .DEPTH (LATENCY - 1)
            ) u_line (
                .i_clk   (i_clk),
                .i_rst_n (i_rst_n),
                .i_digit (i_raw.digit[g]),
                .o_digit (aligned[g])
            );

            // Each line must deliver its digit exactly four clocks later
            chk_stage_aligned: assert property (@(posedge i_clk) disable iff (!i_rst_n)
                aligned[g] == $past(i_raw.digit[g], LATENCY - 1))
                else $error("stage digit not aligned");
        end
    endgenerate

    // Error correction: weight stage i by 2^(8-i), last stage by 2
    logic [WORD_W+1:0] sum;
    logic [WORD_W-1:0] next_word;

    always_comb
    begin
        sum = '0;
        for (int i = 0; i < STAGES; i++)
            sum = sum + ({10'h000, aligned[i]}
                << ((i == STAGES - 1) ? 1 : (STAGES - 1 - i)));
        // Clamp keeps the transfer monotonic at both ends
        if (sum[WORD_W+1])
            next_word = ZERO_WORD;
        else if (sum[WORD_W])
            next_word = '1;
        else
            next_word = sum[WORD_W-1:0];
    end

    // Output register: alignment (4 cycles incl. input tap) plus this = 5
    logic [WORD_W-1:0] word;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            word <= MIDSCALE;
        else
            word <= next_word;
    end

    // Invalid window after power-down or reset; pipeline holds stale data
    logic [LAT_W-1:0] settle;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            settle <= LAT_CNT;
        else if (pd_s2)
            settle <= LAT_CNT;
        else if (settle != '0)
            settle <= settle - 3'h1;
    end

    // Drive enables: both static pins gate every line
    logic drive;
    assign drive        = !oe_n_s2 && !pd_s2;
    assign o_bus.data   = word;
    assign o_bus.oe     = {WORD_W{drive}};
    assign o_word_valid = (settle == '0) && !pd_s2;

    // Checks
    sequence s_pd_release;
        pd_s2 ##1 !pd_s2;
    endsequence

    chk_pd_invalid_window: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_pd_release |-> !o_word_valid [*5] ##1 (o_word_valid || pd_s2))
        else $error("valid word too soon after power-down");

    // Pin held high long enough to pass the synchroniser
    sequence s_oe_pin_high;
        i_oe_n [*3];
    endsequence

    // Both pins held low long enough to pass the synchroniser
    sequence s_pins_normal;
        (!i_oe_n && !i_pwrdn) [*3];
    endsequence

    // Power-down pin held high long enough to pass the synchroniser
    sequence s_pd_pin_high;
        i_pwrdn [*3];
    endsequence

    chk_oe_pin_floats: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_oe_pin_high |-> (o_bus.oe == '0))
        else $error("bus driven after enable pin high");

    chk_pins_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_pins_normal |-> (o_bus.oe == '1))
        else $error("bus not driven with pins low");

    chk_pd_pin_floats: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_pd_pin_high |-> (o_bus.oe == '0) && !o_word_valid)
        else $error("bus driven after power-down pin high");

    // A long quiet stretch must end the invalid window
    chk_valid_returns: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_pwrdn [*8]) |-> o_word_valid)
        else $error("word never flagged valid");

    // The window restarts at its full length when power-down ends
    chk_window_reload: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(pd_s2) |-> (settle == LAT_CNT))
        else $error("invalid window not reloaded");

    // The window shrinks by one word per clock
    chk_window_counts: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (settle != '0 && !pd_s2) |=> (settle == $past(settle) - 3'h1))
        else $error("invalid window count skipped");

    chk_oe_floats_bus: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        oe_n_s2 |-> (o_bus.oe == '0))
        else $error("bus driven with enable high");

    chk_pd_floats_bus: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        pd_s2 |-> (o_bus.oe == '0) && !o_word_valid)
        else $error("bus driven in power-down");

    chk_bus_drive_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!oe_n_s2 && !pd_s2) |-> (o_bus.oe == '1))
        else $error("bus not driven in normal mode");

    chk_word_latency: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((i_raw.digit == {STAGES{2'h1}}) [*5]) |=> (o_bus.data == MIDSCALE))
        else $error("midscale word not five cycles after sample");

    chk_full_scale: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((i_raw.digit == {STAGES{2'h2}}) [*5]) |=> (o_bus.data == 10'h3FF))
        else $error("full scale not all ones");

    chk_zero_scale: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((i_raw.digit == '0) [*5]) |=> (o_bus.data == ZERO_WORD))
        else $error("negative full scale not all zeros");

    chk_word_tracks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> (o_bus.data == $past(next_word)))
        else $error("word not updated every clock");
endmodule // pao_port
`default_nettype wire

// file: verification/pao_capture.sv
// Capture-side model that latches words from the output port
`timescale 1ns/1ps
`default_nettype none
module pao_capture
    import pao_pkg::*;
(
    input  wire logic     i_clk,
    input  wire pao_bus_t i_bus,
    input  wire logic     i_valid,
    output logic [WORD_W-1:0] o_word
);
    // Latch driven, valid words; enable pin left alone in normal use
    always_ff @(posedge i_clk)
    begin
        if (i_valid && (&i_bus.oe))
        begin
            o_word <= i_bus.data;
        end
    end
endmodule // pao_capture
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the converter output port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pao_pkg::*;
    logic              i_clk = 1'b0;
    logic              i_rst_n = 1'b0;
    pao_raw_t          i_raw = '0;
    logic              i_oe_n = 1'b0;
    logic              i_pwrdn = 1'b0;
    pao_bus_t          o_bus;
    logic              o_word_valid;
    logic [WORD_W-1:0] cap_word;
    logic [WORD_W-1:0] exp_q[$];
    logic [WORD_W-1:0] e;
    pao_raw_t          r;
    int                fail_count = 0;
    int                cmp_count = 0;
    int                cycles = 0;
    integer            seed = 32'h990D12E8;

    pao_port uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_raw(i_raw), .i_oe_n(i_oe_n),
        .i_pwrdn(i_pwrdn), .o_bus(o_bus), .o_word_valid(o_word_valid));
    pao_capture cap (.i_clk(i_clk), .i_bus(o_bus), .i_valid(o_word_valid), .o_word(cap_word));

    always #10 i_clk = ~i_clk;

    // Hang guard
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [WORD_W-1:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Weighted sum of redundant digits, clamped to the code range
    function automatic logic [WORD_W-1:0] model_word(pao_raw_t w);
        int s;
        s = 0;
        for (int i = 0; i < STAGES; i++)
            s += int'(w.digit[i]) << ((i == STAGES - 1) ? 1 : (8 - i));
        if (s < 0)
            s = 0;
        if (s > 1023)
            s = 1023;
        return s[WORD_W-1:0];
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Held words: all 0, all 1, all 2, then random digits 0..2
    task automatic run_words(input int n);
        for (int t = 0; t < n; t++)
        begin
            for (int i = 0; i < STAGES; i++)
                r.digit[i] = (t < 3) ? 2'(t) : 2'({$random(seed)} % 3);
            @(negedge i_clk);
            i_raw = r;
            exp_q.push_back(model_word(r));
            repeat (9) @(negedge i_clk);
            e = exp_q.pop_front();
            check("data", o_bus.data, e);
            check("capture", cap_word, e);
        end
    endtask

    initial
    begin
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        run_words(12);
        $display("test words done");
        i_oe_n = 1'b1;
        repeat (3) @(negedge i_clk);
        check("oe", o_bus.oe, ZERO_WORD);
        i_oe_n = 1'b0;
        repeat (3) @(negedge i_clk);
        check("oe", o_bus.oe, 10'h3FF);
        $display("test enable done");
        i_pwrdn = 1'b1;
        repeat (3) @(negedge i_clk);
        check("oe", o_bus.oe, ZERO_WORD);
        check("valid", {9'h000, o_word_valid}, 10'h000);
        i_pwrdn = 1'b0;
        repeat (4) @(negedge i_clk);
        check("valid", {9'h000, o_word_valid}, 10'h000);
        repeat (6) @(negedge i_clk);
        check("valid", {9'h000, o_word_valid}, 10'h001);
        run_words(4);
        $display("test power-down done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
